// ==== hdl/can_flt_pkg.sv ====
// Constants, register map and carrier types of the acceptance filter bank
package can_flt_pkg;

   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int ADDR_W    = 6;
   localparam int DATA_W    = 16;
   localparam int NFILT     = 16;
   localparam int NMASK     = 3;
   localparam int SID_W     = 11;
   localparam int EID_W     = 18;
   localparam int EIDH_W    = 2;
   localparam int PTR_W     = 4;
   localparam int PTR_PER   = 4;
   localparam int MSEL_W    = 2;
   localparam int MSEL_PER  = 8;

   // ----------------------------------------------------------------
   // Register word addresses
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] A_FEN   = 6'h00;
   localparam logic [ADDR_W-1:0] A_PTR0  = 6'h01;
   localparam logic [ADDR_W-1:0] A_PTR3  = 6'h04;
   localparam logic [ADDR_W-1:0] A_MSEL0 = 6'h05;
   localparam logic [ADDR_W-1:0] A_MSEL1 = 6'h06;
   localparam logic [ADDR_W-1:0] A_STAT  = 6'h07;
   localparam logic [ADDR_W-1:0] A_MASK0 = 6'h08;
   localparam logic [ADDR_W-1:0] A_MASKE = 6'h0D;
   localparam logic [ADDR_W-1:0] A_FILT0 = 6'h20;

   // ----------------------------------------------------------------
   // Fields and reset values
   // ----------------------------------------------------------------
   localparam int SID_LSB   = 5;
   localparam int FRAME_TYPE_SELECT_BIT = 3;
   localparam logic [DATA_W-1:0] FEN_RST   = 16'hFFFF;
   localparam logic [DATA_W-1:0] SID_WMASK = 16'hFFEB;
   localparam logic [PTR_W-1:0]  BUF_FIFO  = 4'hF;
   localparam logic [MSEL_W-1:0] MSEL_RSVD = 2'h3;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic             is_ext;
      logic [SID_W-1:0] sid;
      logic [EID_W-1:0] eid;
   } msg_t;

   typedef struct packed {
      logic [SID_W-1:0] sid;
      logic             frame_type_select;
      logic [EID_W-1:0] eid;
   } filt_t;

   typedef struct packed {
      logic [SID_W-1:0] sid;
      logic             frame_type_match_enable;
      logic [EID_W-1:0] eid;
   } mask_t;

   typedef struct packed {
      logic             fifo;
      logic [3:0]       filter;
      logic [PTR_W-1:0] buffer;
   } result_t;

endpackage : can_flt_pkg

// ==== hdl/filter_compare.sv ====
// One acceptance filter: masked identifier and frame-type comparison
`timescale 1ns/10ps
module filter_compare
(
   // Clock and reset, watched by the checks only
   input  wire logic               core_clk,
   input  wire logic               rst_n,
   // Filter setup
   input  wire logic               enable,
   input  wire can_flt_pkg::filt_t pat,
   input  wire can_flt_pkg::mask_t mask,
   // Received identifier
   input  wire can_flt_pkg::msg_t  msg,
   output logic                    hit
);

   logic sid_ok;
   logic eid_ok;
   logic type_ok;

   assign sid_ok  = ((msg.sid ^ pat.sid) & mask.sid) == '0;
   assign eid_ok  = ((msg.eid ^ pat.eid) & mask.eid) == '0;
   // Select only matters while match enable is set
   assign type_ok = !mask.frame_type_match_enable || (msg.is_ext == pat.frame_type_select);
   assign hit     = enable && sid_ok && type_ok
                    && (!msg.is_ext || eid_ok);

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sid_mismatch_a : assert property (
      @(posedge core_clk) disable iff (!rst_n)
      ((msg.sid ^ pat.sid) & mask.sid) != '0 |-> !hit)
      else $error("hit despite masked standard id mismatch");

   frame_type_a : assert property (
      @(posedge core_clk) disable iff (!rst_n)
      mask.frame_type_match_enable && (msg.is_ext != pat.frame_type_select) |-> !hit)
      else $error("hit with wrong frame type");

   ext_mismatch_a : assert property (
      @(posedge core_clk) disable iff (!rst_n)
      msg.is_ext && ((msg.eid ^ pat.eid) & mask.eid) != '0 |-> !hit)
      else $error("hit despite masked extended id mismatch");

   either_type_a : assert property (
      @(posedge core_clk) disable iff (!rst_n)
      enable && !mask.frame_type_match_enable && sid_ok && (!msg.is_ext || eid_ok)
      |-> hit)
      else $error("masked match without frame-type check missed");

   disabled_filter_a : assert property (
      @(posedge core_clk) disable iff (!rst_n)
      !enable |-> !hit)
      else $error("disabled filter hit");

endmodule : filter_compare

// ==== hdl/can_acceptance_filter_routing.sv ====
// Sixteen acceptance filters with mask selection and buffer routing
`timescale 1ns/10ps
module can_acceptance_filter_routing
(
   // Clock and reset
   input  wire logic                            core_clk,
   input  wire logic                            rst_n,
   // Register port
   input  wire logic [can_flt_pkg::ADDR_W-1:0] reg_addr,
   input  wire logic [can_flt_pkg::DATA_W-1:0] reg_wdata,
   input  wire logic                            reg_wr,
   input  wire logic                            reg_rd,
   output logic      [can_flt_pkg::DATA_W-1:0] reg_rdata,
   // Identifier from the protocol engine
   input  wire logic                            id_valid,
   input  wire can_flt_pkg::msg_t               id_msg,
   // Routing decision
   output logic                                 acc_valid,
   output can_flt_pkg::result_t                 acc_result
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic [can_flt_pkg::DATA_W-1:0] fen,  next_fen;
   logic [can_flt_pkg::DATA_W-1:0] ptr  [4];
   logic [can_flt_pkg::DATA_W-1:0] next_ptr [4];
   logic [can_flt_pkg::DATA_W-1:0] msel [2];
   logic [can_flt_pkg::DATA_W-1:0] next_msel [2];
   logic [can_flt_pkg::DATA_W-1:0] msid [can_flt_pkg::NMASK];
   logic [can_flt_pkg::DATA_W-1:0] meid [can_flt_pkg::NMASK];
   logic [can_flt_pkg::DATA_W-1:0] next_msid [can_flt_pkg::NMASK];
   logic [can_flt_pkg::DATA_W-1:0] next_meid [can_flt_pkg::NMASK];
   logic [can_flt_pkg::DATA_W-1:0] fsid [can_flt_pkg::NFILT];
   logic [can_flt_pkg::DATA_W-1:0] feid [can_flt_pkg::NFILT];
   logic [can_flt_pkg::DATA_W-1:0] next_fsid [can_flt_pkg::NFILT];
   logic [can_flt_pkg::DATA_W-1:0] next_feid [can_flt_pkg::NFILT];
   logic                            seen, next_seen;
   logic                            next_acc_valid;
   can_flt_pkg::result_t            next_acc;
   logic [can_flt_pkg::DATA_W-1:0] next_rdata;

   logic [can_flt_pkg::NFILT-1:0]  hits;
   logic [can_flt_pkg::PTR_W-1:0]  target [can_flt_pkg::NFILT];
   logic [63:0]                     ptr_flat;
   logic [can_flt_pkg::ADDR_W-1:0] mask_off;
   logic [3:0]                      filt_idx;
   logic                            is_filt;
   logic                            is_mask;

   assign ptr_flat = {ptr[3], ptr[2], ptr[1], ptr[0]};
   assign is_filt  = reg_addr >= can_flt_pkg::A_FILT0;
   assign is_mask  = reg_addr >= can_flt_pkg::A_MASK0
                     && reg_addr <= can_flt_pkg::A_MASKE;
   assign mask_off = reg_addr - can_flt_pkg::A_MASK0;
   assign filt_idx = reg_addr[4:1];

   // ----------------------------------------------------------------
   // Filter bank
   // ----------------------------------------------------------------
   for (genvar i = 0; i < can_flt_pkg::NFILT; i++)
   begin : g_flt
      logic [can_flt_pkg::MSEL_W-1:0] sel;
      logic [1:0]                     mk;
      can_flt_pkg::filt_t             pat;
      can_flt_pkg::mask_t             msk;

      assign sel = msel[i / can_flt_pkg::MSEL_PER]
                   [(i % can_flt_pkg::MSEL_PER) * can_flt_pkg::MSEL_W
                    +: can_flt_pkg::MSEL_W];
      // Reserved source falls back to mask 0 rather than an X index
      assign mk  = (sel == can_flt_pkg::MSEL_RSVD) ? 2'h0 : sel;
      assign target[i] = ptr[i / can_flt_pkg::PTR_PER]
                   [(i % can_flt_pkg::PTR_PER) * can_flt_pkg::PTR_W
                    +: can_flt_pkg::PTR_W];
      assign pat.sid   = fsid[i][can_flt_pkg::SID_LSB +: can_flt_pkg::SID_W];
      assign pat.frame_type_select = fsid[i][can_flt_pkg::FRAME_TYPE_SELECT_BIT];
      assign pat.eid   = {fsid[i][can_flt_pkg::EIDH_W-1:0], feid[i]};
      assign msk.sid   = msid[mk][can_flt_pkg::SID_LSB +: can_flt_pkg::SID_W];
      assign msk.frame_type_match_enable  = msid[mk][can_flt_pkg::FRAME_TYPE_SELECT_BIT];
      assign msk.eid   = {msid[mk][can_flt_pkg::EIDH_W-1:0], meid[mk]};

      filter_compare u_cmp
      (
         .core_clk (core_clk),
         .rst_n    (rst_n),
         .enable   (fen[i]),
         .pat      (pat),
         .mask     (msk),
         .msg      (id_msg),
         .hit      (hits[i])
      );
   end

   // ----------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------
   always_comb
   begin
      next_fen  = fen;
      next_ptr  = ptr;
      next_msel = msel;
      if (reg_wr)
      begin
         case (reg_addr)
            can_flt_pkg::A_FEN:   next_fen = reg_wdata;
            can_flt_pkg::A_MSEL0: next_msel[0] = reg_wdata;
            can_flt_pkg::A_MSEL1: next_msel[1] = reg_wdata;
            default:
            begin
               if (reg_addr >= can_flt_pkg::A_PTR0
                   && reg_addr <= can_flt_pkg::A_PTR3)
                  next_ptr[2'(reg_addr - can_flt_pkg::A_PTR0)] = reg_wdata;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         fen  <= can_flt_pkg::FEN_RST;
         ptr  <= '{default: '0};
         msel <= '{default: '0};
      end
      else
      begin
         fen  <= next_fen;
         ptr  <= next_ptr;
         msel <= next_msel;
      end
   end

   // ----------------------------------------------------------------
   // Pattern and mask storage, deliberately not reset
   // ----------------------------------------------------------------
   always_comb
   begin
      next_fsid = fsid;
      next_feid = feid;
      next_msid = msid;
      next_meid = meid;
      if (reg_wr && is_filt)
      begin
         if (reg_addr[0])
            next_feid[filt_idx] = reg_wdata;
         else
            next_fsid[filt_idx] = reg_wdata & can_flt_pkg::SID_WMASK;
      end
      else if (reg_wr && is_mask)
      begin
         if (mask_off[0])
            next_meid[mask_off[2:1]] = reg_wdata;
         else
            next_msid[mask_off[2:1]] = reg_wdata & can_flt_pkg::SID_WMASK;
      end
   end

   always_ff @(posedge core_clk)
   begin
      fsid <= next_fsid;
      feid <= next_feid;
      msid <= next_msid;
      meid <= next_meid;
   end

   // ----------------------------------------------------------------
   // Acceptance and routing
   // ----------------------------------------------------------------
   always_comb
   begin
      next_acc_valid = 1'b0;
      next_acc       = acc_result;
      next_seen      = seen;
      if (id_valid && hits != '0)
      begin
         next_acc_valid = 1'b1;
         next_seen      = 1'b1;
         // Lowest numbered filter wins a multiple hit
         for (int k = can_flt_pkg::NFILT - 1; k >= 0; k--)
         begin
            if (hits[k])
            begin
               next_acc.filter = 4'(k);
               next_acc.buffer = target[k];
            end
         end
         next_acc.fifo = next_acc.buffer == can_flt_pkg::BUF_FIFO;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         acc_valid  <= 1'b0;
         acc_result <= '0;
         seen       <= 1'b0;
      end
      else
      begin
         acc_valid  <= next_acc_valid;
         acc_result <= next_acc;
         seen       <= next_seen;
      end
   end

   // ----------------------------------------------------------------
   // Read port
   // ----------------------------------------------------------------
   always_comb
   begin
      next_rdata = '0;
      if (reg_rd)
      begin
         if (is_filt)
            next_rdata = reg_addr[0] ? feid[filt_idx] : fsid[filt_idx];
         else if (is_mask)
            next_rdata = mask_off[0] ? meid[mask_off[2:1]]
                                     : msid[mask_off[2:1]];
         else if (reg_addr >= can_flt_pkg::A_PTR0
                  && reg_addr <= can_flt_pkg::A_PTR3)
            next_rdata = ptr[2'(reg_addr - can_flt_pkg::A_PTR0)];
         else
         begin
            case (reg_addr)
               can_flt_pkg::A_FEN:   next_rdata = fen;
               can_flt_pkg::A_MSEL0: next_rdata = msel[0];
               can_flt_pkg::A_MSEL1: next_rdata = msel[1];
               can_flt_pkg::A_STAT:
                  next_rdata = {6'h00, seen, acc_result};
               default:              next_rdata = '0;
            endcase
         end
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
         reg_rdata <= '0;
      else
         reg_rdata <= next_rdata;
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence filt_sid_rd_s;
      reg_rd && is_filt && !reg_addr[0];
   endsequence

   reserved_bits_a : assert property (
      @(posedge core_clk) disable iff (!rst_n)
      filt_sid_rd_s |=> reg_rdata[4] == 1'b0 && reg_rdata[2] == 1'b0)
      else $error("unimplemented pattern bit read as one");

   buffer_route_a : assert property (
      @(posedge core_clk) disable iff (!rst_n)
      acc_valid && $stable(ptr_flat)
      |-> acc_result.buffer == target[acc_result.filter])
      else $error("accepted message routed to wrong buffer");

   fifo_decode_a : assert property (
      @(posedge core_clk) disable iff (!rst_n)
      acc_valid |-> acc_result.fifo
                    == (acc_result.buffer == can_flt_pkg::BUF_FIFO))
      else $error("fifo flag disagrees with pointer");

   winner_hit_a : assert property (
      @(posedge core_clk) disable iff (!rst_n)
      acc_valid |-> (($past(hits) >> acc_result.filter) & 16'h0001)
                    == 16'h0001)
      else $error("reported filter did not hit");

   enable_gate_a : assert property (
      @(posedge core_clk) disable iff (!rst_n)
      (hits & ~fen) == '0)
      else $error("disabled filter reported a hit");

   no_accept_a : assert property (
      @(posedge core_clk) disable iff (!rst_n)
      !id_valid || hits == '0 |=> !acc_valid)
      else $error("acceptance without a hit");

   reset_clear_a : assert property (
      @(posedge core_clk)
      !rst_n |=> ptr_flat == '0 && msel[0] == '0 && msel[1] == '0)
      else $error("pointers or mask sources not cleared");

   lowest_wins_a : assert property (
      @(posedge core_clk) disable iff (!rst_n)
      acc_valid |-> ($past(hits) & ((16'h0001 << acc_result.filter)
                    - 16'h0001)) == 16'h0000)
      else $error("lower numbered hit passed over");

   // Refused identifiers leave the last routing in place
   result_hold_a : assert property (
      @(posedge core_clk) disable iff (!rst_n)
      !acc_valid |-> $stable(acc_result))
      else $error("routing result moved without an acceptance");

   rdata_idle_a : assert property (
      @(posedge core_clk) disable iff (!rst_n)
      !reg_rd |=> reg_rdata == '0)
      else $error("read data stands without a read");

endmodule : can_acceptance_filter_routing

// ==== dv/id_source.sv ====
// Protocol engine model that hands received identifiers to the filter bank
`timescale 1ns/10ps
module id_source
(
   // Clock
   input  wire logic          core_clk,
   // Identifier handed to the filters
   output logic               id_valid,
   output can_flt_pkg::msg_t  id_msg
);

   initial
   begin
      id_valid = 1'b0;
      id_msg   = '0;
   end

   // ---------------------------------------------
   // One identifier per call, one-cycle valid
   // ---------------------------------------------
   // Idle bus shows the inverse so stale ids never look valid
   task automatic send(input can_flt_pkg::msg_t m);
      @(posedge core_clk);
      id_valid <= 1'b1;
      id_msg   <= m;
      @(posedge core_clk);
      id_valid <= 1'b0;
      id_msg   <= can_flt_pkg::msg_t'(~m);
   endtask : send

endmodule : id_source

// ==== dv/tb.sv ====
// Self-checking bench for the acceptance filter and routing block
`timescale 1ns/10ps
module tb;

   logic                    core_clk;
   logic                    rst_n;
   logic [5:0]              reg_addr;
   logic [15:0]             reg_wdata;
   logic                    reg_wr;
   logic                    reg_rd;
   logic [15:0]             reg_rdata;
   logic                    id_valid;
   can_flt_pkg::msg_t       id_msg;
   logic                    acc_valid;
   can_flt_pkg::result_t    acc_result;
   int                      n_fail;
   int                      n_tests;
   logic [8:0]              last_res;
   logic [15:0]             rv;
   logic [15:0]             w;

   can_acceptance_filter_routing dut_u (
      .core_clk   (core_clk),
      .rst_n      (rst_n),
      .reg_addr   (reg_addr),
      .reg_wdata  (reg_wdata),
      .reg_wr     (reg_wr),
      .reg_rd     (reg_rd),
      .reg_rdata  (reg_rdata),
      .id_valid   (id_valid),
      .id_msg     (id_msg),
      .acc_valid  (acc_valid),
      .acc_result (acc_result)
   );

   id_source src_u (
      .core_clk (core_clk),
      .id_valid (id_valid),
      .id_msg   (id_msg)
   );

   // ---------------------------------------------
   // Shared tasks
   // ---------------------------------------------
   task automatic close_out();
      if (n_fail == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : close_out

   task automatic chk(input string nm, input logic [15:0] seen,
                      input logic [15:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      @(posedge core_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr    <= 1'b0;
   endtask : wr

   task automatic rd(input logic [5:0] a, output logic [15:0] d);
      @(posedge core_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd   <= 1'b0;
      #1;
      d = reg_rdata;
   endtask : rd

   // Pointer of filter n is 15-n: filter 0 lands in the FIFO
   function automatic logic [8:0] res(input int n);
      logic [3:0] p;
      p = 4'hF - 4'(n);
      return {p == 4'hF, 4'(n), p};
   endfunction : res

   task automatic snd(input logic e, input logic [10:0] s,
                      input logic [17:0] x, input logic hit, input int n);
      can_flt_pkg::msg_t m;
      m = '{is_ext: e, sid: s, eid: x};
      src_u.send(m);
      #1;
      if (hit)
         last_res = res(n);
      chk("acc_valid", {15'h0000, acc_valid}, {15'h0000, hit});
      chk("acc_result", {7'h00, acc_result}, {7'h00, last_res});
   endtask : snd

   // ---------------------------------------------
   // Clock, watchdog
   // ---------------------------------------------
   initial
   begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   initial
   begin
      repeat (20000) @(posedge core_clk);
      n_fail++;
      close_out();
   end

   // ---------------------------------------------
   // Main sequence
   // ---------------------------------------------
   initial
   begin
      n_fail = 0;
      n_tests = 0;
      last_res = 9'h000;
      rst_n = 1'b0;
      reg_addr = 6'h00;
      reg_wdata = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      rd(6'h00, rv);
      chk("enables", rv, 16'hFFFF);
      for (int a = 1; a <= 6; a++)
      begin
         rd(6'(a), rv);
         chk("ptr_msel_rst", rv, 16'h0000);
      end
      for (int k = 0; k < 4; k++)
      begin
         for (int j = 0; j < 4; j++)
            w[4*j +: 4] = 4'hF - 4'(4*k + j);
         wr(6'(1 + k), w);
         rd(6'(1 + k), rv);
         chk("ptr_rb", rv, w);
      end
      wr(6'h10, 16'hFFFF);
      rd(6'h10, rv);
      chk("unmapped", rv, 16'h0000);
      // Mask 0 full compare, mask 1 full with type match, mask 2 open
      wr(6'h08, 16'hFFE3);
      wr(6'h09, 16'hFFFF);
      wr(6'h0A, 16'hFFFF);
      rd(6'h0A, rv);
      chk("mask_unimpl", rv, 16'hFFEB);
      wr(6'h0B, 16'hFFFF);
      wr(6'h0C, 16'h0000);
      wr(6'h0D, 16'h0000);
      for (int n = 0; n < 16; n++)
      begin
         wr(6'h20 + 6'(2*n), 16'(n) << 5);
         wr(6'h21 + 6'(2*n), 16'h0000);
      end
      wr(6'h20, 16'hFFFF);
      rd(6'h20, rv);
      chk("pat_unimpl", rv, 16'hFFEB);
      wr(6'h20, 16'h0000);
      for (int n = 0; n < 16; n++)
         snd(1'b0, 11'(n), 18'h00000, 1'b1, n);
      wr(6'h00, 16'hFFF7);
      snd(1'b0, 11'h003, 18'h00000, 1'b0, 0);
      snd(1'b0, 11'h7FF, 18'h00000, 1'b0, 0);
      // Filter 2 extended pattern, frame select set
      wr(6'h24, 16'h004A);
      wr(6'h25, 16'h1234);
      snd(1'b0, 11'h002, 18'h00000, 1'b1, 2);
      snd(1'b1, 11'h002, 18'h21234, 1'b1, 2);
      snd(1'b1, 11'h002, 18'h01234, 1'b0, 0);
      snd(1'b1, 11'h002, 18'h21235, 1'b0, 0);
      // Reserved source 11 is never programmed
      wr(6'h05, 16'h0010);
      snd(1'b0, 11'h002, 18'h00000, 1'b0, 0);
      snd(1'b1, 11'h002, 18'h21234, 1'b1, 2);
      wr(6'h24, 16'h0042);
      snd(1'b0, 11'h002, 18'h00000, 1'b1, 2);
      snd(1'b1, 11'h002, 18'h21234, 1'b0, 0);
      wr(6'h05, 16'h0020);
      snd(1'b1, 11'h555, 18'h2AAAA, 1'b1, 2);
      wr(6'h05, 16'h8001);
      rd(6'h05, rv);
      chk("msel_rb", rv, 16'h8001);
      // Second mask source word; filter 7 on the open mask wins first
      wr(6'h06, 16'h0020);
      snd(1'b0, 11'h555, 18'h00000, 1'b1, 7);
      wr(6'h05, 16'h0000);
      snd(1'b0, 11'h555, 18'h00000, 1'b1, 10);
      rd(6'h07, rv);
      chk("status", rv, 16'h02A5);
      // Mid-run reset clears routing setup again
      @(posedge core_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      rd(6'h04, rv);
      chk("ptr_rst", rv, 16'h0000);
      rd(6'h06, rv);
      chk("msel_rst", rv, 16'h0000);
      rd(6'h07, rv);
      chk("status_rst", rv, 16'h0000);
      close_out();
   end

endmodule : tb
